// File: design/epsc_pkg.sv
// shared constants and types of the e-paper command decoder
package epsc_pkg;
  // opcodes
  localparam logic [7:0] OP_INIT_WR  = 8'h09;
  localparam logic [7:0] OP_INIT_RD  = 8'h0a;
  localparam logic [7:0] OP_BOOST    = 8'h0c;
  localparam logic [7:0] OP_SLEEP    = 8'h10;
  localparam logic [7:0] OP_SWRST    = 8'h12;
  localparam logic [7:0] OP_HV_DET   = 8'h14;
  localparam logic [7:0] OP_VCI_DET  = 8'h15;
  localparam logic [7:0] OP_TSEL     = 8'h18;
  localparam logic [7:0] OP_TEMP_WR  = 8'h1a;
  localparam logic [7:0] OP_TEMP_RD  = 8'h1b;
  localparam logic [7:0] OP_SENS_WR  = 8'h1c;
  localparam logic [7:0] OP_ACTIVATE = 8'h20;
  localparam logic [7:0] OP_RAMOPT   = 8'h21;
  localparam logic [7:0] OP_STATUS   = 8'h2f;
  // serial framing
  localparam logic [3:0] LEN_4WIRE   = 4'h8;
  localparam logic [3:0] LEN_3WIRE   = 4'h9;
  // reset values and limits on accepted codes
  localparam logic [31:0] INIT_RST   = 32'h0000_0000;
  localparam logic [7:0] BOOST1_RST  = 8'h8b;
  localparam logic [7:0] BOOST2_RST  = 8'h9c;
  localparam logic [7:0] BOOST3_RST  = 8'h96;
  localparam logic [7:0] BOOSTD_RST  = 8'h0f;
  localparam logic [3:0] OFF_MIN     = 4'h4;
  localparam logic [1:0] SLEEP_NORM  = 2'h0;
  localparam logic [1:0] SLEEP_BAD   = 2'h2;
  localparam logic [2:0] VCI_RST     = 3'h4;
  localparam logic [2:0] VCI_MIN     = 3'h3;
  localparam logic [7:0] TSEL_RST    = 8'h48;
  localparam logic [11:0] TEMP_RST   = 12'h7ff;
  localparam logic [15:0] RAMOPT_RST = 16'h0000;
  localparam logic [7:0] SENS_RST    = 8'h00;
  // external sensor write modes
  localparam logic [1:0] SM_PTR      = 2'h0;
  localparam logic [1:0] SM_P1       = 2'h1;
  localparam logic [1:0] SM_P2       = 2'h2;
  // status byte fields
  localparam int unsigned ST_HV      = 5;
  localparam int unsigned ST_VCI     = 4;
  localparam int unsigned ST_BUSY    = 2;
  // arbitrary identification value
  localparam logic [1:0] CHIP_ID     = 2'h1;
  // timing
  localparam int unsigned CLK_NS     = 10;
  localparam int unsigned COOL_NS    = 10_000_000;
  localparam int unsigned COOL_CYC   = COOL_NS / CLK_NS;
  localparam int unsigned SETTLE_NS  = 1_000;
  localparam int unsigned SETTLE_CYC = SETTLE_NS / CLK_NS;
  localparam int unsigned SWRST_NS   = 2_000;
  localparam int unsigned SWRST_CYC  = SWRST_NS / CLK_NS;
  localparam int unsigned I2C_QTR_NS = 2_500;
  localparam int unsigned I2C_QTR_CYC = I2C_QTR_NS / CLK_NS;

  typedef struct packed {
    logic       dc;
    logic [7:0] data;
  } epsc_rx_t;

  typedef struct packed {
    logic [7:0] ph1;
    logic [7:0] ph2;
    logic [7:0] ph3;
    logic [7:0] dur;
  } epsc_boost_t;

  typedef enum logic [2:0] {
    E_IDLE, E_SWRST, E_COOL, E_HVCHK, E_VCI, E_SENS, E_UPD
  } epsc_eng_t;
endpackage : epsc_pkg

// File: design/epsc_sync.sv
// two-stage synchroniser for a vector of asynchronous levels
module epsc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rstn,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      meta   <= '0;
      o_sync <= '0;
    end else if (i_ce) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : epsc_sync

// File: design/epsc_i2c_wr.sv
// two-wire master that writes one to four bytes to the external sensor
module epsc_i2c_wr #(
  parameter int unsigned QTR = epsc_pkg::I2C_QTR_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  input  wire logic       i_start,
  input  wire logic [1:0] i_mode,
  input  wire logic [6:0] i_addr,
  input  wire logic [5:0] i_ptr,
  input  wire logic [7:0] i_p1,
  input  wire logic [7:0] i_p2,
  input  wire logic       i_sda,
  output logic            o_done,
  output logic            o_nack,
  output logic            o_scl,
  output logic            o_scl_oe,
  output logic            o_sda,
  output logic            o_sda_oe
);
  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} epsc_i2c_t;
  epsc_i2c_t   st;
  logic [15:0] qcnt;
  logic [1:0]  ph;
  logic [3:0]  bitn;
  logic [1:0]  byten;
  logic [1:0]  last;
  logic [31:0] frame;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= S_IDLE;
      qcnt <= '0;
      ph <= '0;
      bitn <= '0;
      byten <= '0;
      last <= '0;
      frame <= '0;
      o_done <= 1'b0;
      o_nack <= 1'b0;
      o_scl <= 1'b0;
      o_sda <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (st == S_IDLE) begin
        if (i_start) begin
          frame <= {i_addr, 1'b0, 2'b00, i_ptr, i_p1, i_p2};
          unique case (i_mode)
            epsc_pkg::SM_PTR: last <= 2'd1;
            epsc_pkg::SM_P1:  last <= 2'd2;
            epsc_pkg::SM_P2:  last <= 2'd3;
            default:          last <= 2'd0;
          endcase
          st <= S_START;
          ph <= '0;
          qcnt <= 16'(QTR - 1);
          o_nack <= 1'b0;
        end
      end else if (qcnt != '0) begin
        qcnt <= qcnt - 16'd1;
      end else begin
        qcnt <= 16'(QTR - 1);
        ph <= ph + 2'd1;
        unique case (st)
          S_START: begin
            if (ph == 2'd1) o_sda_oe <= 1'b1;
            if (ph == 2'd2) o_scl_oe <= 1'b1;
            if (ph == 2'd3) begin
              st <= S_DATA;
              bitn <= '0;
              byten <= '0;
            end
          end
          S_DATA: begin
            if (ph == 2'd0) o_sda_oe <= (bitn != 4'd8) && !frame[31];
            if (ph == 2'd1) o_scl_oe <= 1'b0;
            if (ph == 2'd2 && bitn == 4'd8 && i_sda) o_nack <= 1'b1;
            if (ph == 2'd3) begin
              o_scl_oe <= 1'b1;
              if (bitn == 4'd8) begin
                bitn <= '0;
                if (byten == last) st <= S_STOP;
                else byten <= byten + 2'd1;
              end else begin
                bitn <= bitn + 4'd1;
                frame <= {frame[30:0], 1'b0};
              end
            end
          end
          default: begin
            if (ph == 2'd0) o_sda_oe <= 1'b1;
            if (ph == 2'd1) o_scl_oe <= 1'b0;
            if (ph == 2'd2) o_sda_oe <= 1'b0;
            if (ph == 2'd3) begin
              st <= S_IDLE;
              o_done <= 1'b1;
            end
          end
        endcase
      end
    end
  end
endmodule : epsc_i2c_wr

// File: design/epsc_cmd_decoder.sv
// command decoder for power, sensing and update commands of the panel driver
// Contract
// - command select low means opcode, high data
// - width select high: nine-bit frames, else eight
// - opcode 09h stores four initial code bytes
// - opcode 0Ah reads initial code bytes back
// - phase byte: strength 6:4, off time 3:0
// - duration byte holds three two-bit phase fields
// - opcode 14h runs readiness detection with busy
// - cool-down ten ms times n+1, m loops
// - parameter zero means one single check
// - supply threshold code 011 to 111 only
// - opcode 15h runs supply detection with busy
// - opcode 18h selects temperature sensor source
// - opcode 1Ah loads twelve-bit temperature register
// - opcode 1Bh returns temperature, upper bits first
// - opcode 12h restores defaults except sleep and status flags, busy
// - opcode 1Ch takes mode, pointer, two parameters
// - sensor write runs on two-wire master, busy
// - opcode 20h starts update sequence with busy
// - opcode 21h stores two RAM option bytes
module epsc_cmd_decoder #(
  parameter int unsigned COOL_CYC    = epsc_pkg::COOL_CYC,
  parameter logic [6:0]  SENSOR_ADDR = 7'h48
) (
  input  wire logic           i_clk_sys,
  input  wire logic           i_rstn,
  input  wire logic           i_ce,
  input  wire logic           i_iface_width_select,
  input  wire logic           i_spi_csn,
  input  wire logic           i_spi_sclk,
  input  wire logic           i_spi_sda,
  input  wire logic           i_spi_dc,
  input  wire logic           i_clock_gate_enable_bit,
  input  wire logic           i_analog_block_enable_bit,
  input  wire logic           i_hv_ready,
  input  wire logic           i_supply_low,
  input  wire logic           i_update_done,
  input  wire logic           i_sensor_link_data,
  output logic                o_spi_sda,
  output logic                o_spi_sda_oe,
  output logic                o_busy,
  output logic                o_sensor_link_clock,
  output logic                o_sensor_link_clock_oe,
  output logic                o_sensor_link_data,
  output logic                o_sensor_link_data_oe,
  output logic [31:0]         o_init_code,
  output epsc_pkg::epsc_boost_t o_boost,
  output logic [1:0]          o_sleep_mode,
  output logic [2:0]          o_supply_level,
  output logic [7:0]          o_temp_source,
  output logic [11:0]         o_temp,
  output logic [15:0]         o_ram_opt,
  output logic                o_hv_not_ready,
  output logic                o_supply_low,
  output logic                o_sensor_nack,
  output logic                o_update_start
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] sy;
  logic       s_bs;
  logic       s_csn;
  logic       s_sclk;
  logic       s_sda;
  logic       s_dc;
  logic       s_hv;
  logic       s_low;
  logic       s_sensor_link_data;

  epsc_sync #(.W(8)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_async   ({i_iface_width_select, i_spi_csn, i_spi_sclk, i_spi_sda,
                 i_spi_dc, i_hv_ready, i_supply_low, i_sensor_link_data}),
    .o_sync    (sy)
  );
  assign {s_bs, s_csn, s_sclk, s_sda, s_dc, s_hv, s_low, s_sensor_link_data} = sy;

  ////////////////////////////////////////////////////////////////////////////
  // serial receiver
  logic              sclk_d;
  logic [3:0]        cnt;
  logic [8:0]        sh;
  logic              dc3;
  logic              rx_vld;
  epsc_pkg::epsc_rx_t rx;
  logic [3:0]        flen;
  logic              rise;

  assign flen = s_bs ? epsc_pkg::LEN_3WIRE : epsc_pkg::LEN_4WIRE;
  assign rise = s_sclk && !sclk_d && !s_csn;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_d <= 1'b0;
      cnt <= '0;
      sh <= '0;
      dc3 <= 1'b0;
      rx_vld <= 1'b0;
      rx <= '0;
    end else if (i_ce) begin
      sclk_d <= s_sclk;
      rx_vld <= 1'b0;
      if (s_csn) begin
        cnt <= '0;
      end else if (rise) begin
        sh <= {sh[7:0], s_sda};
        if (cnt == '0) dc3 <= s_sda;
        if (cnt == flen - 4'd1) begin
          cnt <= '0;
          rx_vld <= 1'b1;
          rx.data <= {sh[6:0], s_sda};
          rx.dc <= s_bs ? sh[7] : s_dc;
        end else begin
          cnt <= cnt + 4'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command tracking
  epsc_pkg::epsc_eng_t eng;
  logic [7:0] cur_op;
  logic [2:0] idx;
  logic       rd_mode;
  logic [2:0] rd_idx;
  logic       awake;
  logic       cmd_v;
  logic       par_v;

  assign awake = (o_sleep_mode == epsc_pkg::SLEEP_NORM);
  assign cmd_v = rx_vld && !rx.dc && awake;
  assign par_v = rx_vld && rx.dc && awake && !rd_mode;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_op <= '0;
      idx <= '0;
      rd_mode <= 1'b0;
      rd_idx <= '0;
    end else if (i_ce) begin
      if (cmd_v) begin
        cur_op <= rx.data;
        idx <= '0;
        rd_idx <= '0;
        rd_mode <= (rx.data == epsc_pkg::OP_INIT_RD) ||
                   (rx.data == epsc_pkg::OP_TEMP_RD) ||
                   (rx.data == epsc_pkg::OP_STATUS);
      end else if (par_v && idx != 3'd7) begin
        idx <= idx + 3'd1;
      end else if (rx_vld && rx.dc && rd_mode && rd_idx != 3'd7) begin
        rd_idx <= rd_idx + 3'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [7:0] tx_byte;
  logic [7:0] status;
  logic [3:0] dbit;

  assign status = {2'b00, o_hv_not_ready, o_supply_low, 1'b0, o_busy,
                   epsc_pkg::CHIP_ID};
  assign dbit = s_bs ? cnt - 4'd1 : cnt;

  always_comb begin
    tx_byte = 8'h00;
    unique case (cur_op)
      epsc_pkg::OP_INIT_RD:
        if (rd_idx < 3'd4) tx_byte = o_init_code[8*(3-rd_idx[1:0]) +: 8];
      epsc_pkg::OP_TEMP_RD: begin
        if (rd_idx == 3'd0) tx_byte = o_temp[11:4];
        if (rd_idx == 3'd1) tx_byte = {o_temp[3:0], 4'h0};
      end
      epsc_pkg::OP_STATUS:
        if (rd_idx == 3'd0) tx_byte = status;
      default: tx_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_spi_sda <= 1'b0;
      o_spi_sda_oe <= 1'b0;
    end else if (i_ce) begin
      o_spi_sda <= tx_byte[3'(4'd7 - dbit)];
      o_spi_sda_oe <= rd_mode && !s_csn &&
                      (s_bs ? (cnt != '0 && dc3) : s_dc);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start requests
  logic       idle;
  logic       go_swrst;
  logic       go_upd;
  logic       go_hv;
  logic       go_vci;
  logic       go_sens_q;
  logic [7:0] sens_a;
  logic [7:0] sens_b;
  logic [7:0] sens_c;
  logic       sens_done;

  assign idle = (eng == epsc_pkg::E_IDLE);
  assign go_swrst = cmd_v && rx.data == epsc_pkg::OP_SWRST && idle;
  assign go_upd = cmd_v && rx.data == epsc_pkg::OP_ACTIVATE && idle;
  assign go_hv = par_v && cur_op == epsc_pkg::OP_HV_DET && idx == '0 &&
                 i_clock_gate_enable_bit && i_analog_block_enable_bit &&
                 idle;
  assign go_vci = par_v && cur_op == epsc_pkg::OP_VCI_DET && idx == '0 &&
                  i_clock_gate_enable_bit && i_analog_block_enable_bit &&
                  rx.data[2:0] >= epsc_pkg::VCI_MIN && idle;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      go_sens_q <= 1'b0;
    end else if (i_ce) begin
      go_sens_q <= par_v && cur_op == epsc_pkg::OP_SENS_WR && idx == 3'd2 &&
                   i_clock_gate_enable_bit && idle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration store
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_init_code <= epsc_pkg::INIT_RST;
      o_boost <= {epsc_pkg::BOOST1_RST, epsc_pkg::BOOST2_RST,
                  epsc_pkg::BOOST3_RST, epsc_pkg::BOOSTD_RST};
      o_sleep_mode <= epsc_pkg::SLEEP_NORM;
      o_supply_level <= epsc_pkg::VCI_RST;
      o_temp_source <= epsc_pkg::TSEL_RST;
      o_temp <= epsc_pkg::TEMP_RST;
      o_ram_opt <= epsc_pkg::RAMOPT_RST;
      sens_a <= epsc_pkg::SENS_RST;
      sens_b <= epsc_pkg::SENS_RST;
      sens_c <= epsc_pkg::SENS_RST;
    end else if (i_ce) begin
      if (go_swrst) begin
        o_init_code <= epsc_pkg::INIT_RST;
        o_boost <= {epsc_pkg::BOOST1_RST, epsc_pkg::BOOST2_RST,
                    epsc_pkg::BOOST3_RST, epsc_pkg::BOOSTD_RST};
        o_supply_level <= epsc_pkg::VCI_RST;
        o_temp_source <= epsc_pkg::TSEL_RST;
        o_temp <= epsc_pkg::TEMP_RST;
        o_ram_opt <= epsc_pkg::RAMOPT_RST;
        sens_a <= epsc_pkg::SENS_RST;
        sens_b <= epsc_pkg::SENS_RST;
        sens_c <= epsc_pkg::SENS_RST;
      end else if (par_v) begin
        unique case (cur_op)
          epsc_pkg::OP_INIT_WR:
            if (idx < 3'd4) o_init_code[8*(3-idx[1:0]) +: 8] <= rx.data;
          epsc_pkg::OP_BOOST: begin
            // off-time codes below the minimum are dropped
            if (rx.data[3:0] >= epsc_pkg::OFF_MIN) begin
              if (idx == 3'd0) o_boost.ph1 <= {1'b1, rx.data[6:0]};
              if (idx == 3'd1) o_boost.ph2 <= {1'b1, rx.data[6:0]};
              if (idx == 3'd2) o_boost.ph3 <= {1'b1, rx.data[6:0]};
            end
            if (idx == 3'd3) o_boost.dur <= {2'b00, rx.data[5:0]};
          end
          epsc_pkg::OP_SLEEP:
            if (idx == '0 && rx.data[1:0] != epsc_pkg::SLEEP_BAD)
              o_sleep_mode <= rx.data[1:0];
          epsc_pkg::OP_VCI_DET:
            if (idx == '0 && rx.data[2:0] >= epsc_pkg::VCI_MIN)
              o_supply_level <= rx.data[2:0];
          epsc_pkg::OP_TSEL:
            if (idx == '0) o_temp_source <= rx.data;
          epsc_pkg::OP_TEMP_WR: begin
            if (idx == 3'd0) o_temp[11:4] <= rx.data;
            if (idx == 3'd1) o_temp[3:0] <= rx.data[7:4];
          end
          epsc_pkg::OP_SENS_WR: begin
            if (idx == 3'd0) sens_a <= rx.data;
            if (idx == 3'd1) sens_b <= rx.data;
            if (idx == 3'd2) sens_c <= rx.data;
          end
          epsc_pkg::OP_RAMOPT: begin
            if (idx == 3'd0) o_ram_opt[15:8] <= rx.data;
            if (idx == 3'd1) o_ram_opt[7:0] <= rx.data;
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy engine
  logic [31:0] tmr;
  logic [2:0]  unit;
  logic [2:0]  loops;
  logic [2:0]  hv_n;
  logic [2:0]  hv_m;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      eng <= epsc_pkg::E_IDLE;
      tmr <= '0;
      unit <= '0;
      loops <= '0;
      hv_n <= '0;
      hv_m <= '0;
      o_hv_not_ready <= 1'b0;
      o_supply_low <= 1'b0;
      o_update_start <= 1'b0;
    end else if (i_ce) begin
      o_update_start <= 1'b0;
      unique case (eng)
        epsc_pkg::E_IDLE: begin
          if (go_swrst) begin
            eng <= epsc_pkg::E_SWRST;
            tmr <= 32'(epsc_pkg::SWRST_CYC - 1);
          end else if (go_upd) begin
            eng <= epsc_pkg::E_UPD;
            o_update_start <= 1'b1;
          end else if (go_hv) begin
            hv_n <= rx.data[6:4];
            hv_m <= rx.data[2:0];
            unit <= '0;
            loops <= '0;
            if (rx.data == 8'h00) begin
              eng <= epsc_pkg::E_HVCHK;
              tmr <= 32'(epsc_pkg::SETTLE_CYC - 1);
            end else begin
              eng <= epsc_pkg::E_COOL;
              tmr <= 32'(COOL_CYC - 1);
            end
          end else if (go_vci) begin
            eng <= epsc_pkg::E_VCI;
            tmr <= 32'(epsc_pkg::SETTLE_CYC - 1);
          end else if (go_sens_q) begin
            eng <= epsc_pkg::E_SENS;
          end
        end
        epsc_pkg::E_SWRST:
          if (tmr == '0) eng <= epsc_pkg::E_IDLE;
          else tmr <= tmr - 32'd1;
        epsc_pkg::E_COOL:
          if (tmr != '0) begin
            tmr <= tmr - 32'd1;
          end else if (unit == hv_n) begin
            eng <= epsc_pkg::E_HVCHK;
            tmr <= 32'(epsc_pkg::SETTLE_CYC - 1);
          end else begin
            unit <= unit + 3'd1;
            tmr <= 32'(COOL_CYC - 1);
          end
        epsc_pkg::E_HVCHK:
          if (tmr != '0) begin
            tmr <= tmr - 32'd1;
          end else if (s_hv) begin
            o_hv_not_ready <= 1'b0;
            eng <= epsc_pkg::E_IDLE;
          end else if ({1'b0, loops} + 4'd1 >= {1'b0, hv_m}) begin
            o_hv_not_ready <= 1'b1;
            eng <= epsc_pkg::E_IDLE;
          end else begin
            loops <= loops + 3'd1;
            unit <= '0;
            eng <= epsc_pkg::E_COOL;
            tmr <= 32'(COOL_CYC - 1);
          end
        epsc_pkg::E_VCI:
          if (tmr != '0) begin
            tmr <= tmr - 32'd1;
          end else begin
            o_supply_low <= s_low;
            eng <= epsc_pkg::E_IDLE;
          end
        epsc_pkg::E_SENS:
          if (sens_done) eng <= epsc_pkg::E_IDLE;
        epsc_pkg::E_UPD:
          if (i_update_done) eng <= epsc_pkg::E_IDLE;
        default: eng <= epsc_pkg::E_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_busy <= 1'b0;
    end else if (i_ce) begin
      o_busy <= !awake || !idle || go_sens_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external sensor write
  epsc_i2c_wr u_i2c (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_start   (go_sens_q && idle),
    .i_mode    (sens_a[7:6]),
    .i_addr    (SENSOR_ADDR),
    .i_ptr     (sens_a[5:0]),
    .i_p1      (sens_b),
    .i_p2      (sens_c),
    .i_sda     (s_sensor_link_data),
    .o_done    (sens_done),
    .o_nack    (o_sensor_nack),
    .o_scl     (o_sensor_link_clock),
    .o_scl_oe  (o_sensor_link_clock_oe),
    .o_sda     (o_sensor_link_data),
    .o_sda_oe  (o_sensor_link_data_oe)
  );
endmodule : epsc_cmd_decoder

// File: dv/epsc_host.sv
// host controller model driving the serial command link
module epsc_host (
  input  wire logic i_clk_sys,
  input  wire logic i_w9,
  input  wire logic i_sdo,
  output logic      o_csn,
  output logic      o_sclk,
  output logic      o_sda,
  output logic      o_dc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] rd;
  initial {o_csn, o_sclk, o_sda, o_dc} = 4'h9;
  // one frame per call, each sclk level held eight clocks
  task automatic xfer(input logic dc, input logic [7:0] b);
    o_csn <= 1'b0;
    o_dc <= dc;
    for (int i = 8 + int'(i_w9); i > 0; i--) begin
      o_sda <= (i == 9) ? dc : b[3'(i - 1)];
      repeat (8) @(posedge i_clk_sys);
      o_sclk <= 1'b1;
      rd[i-1] <= i_sdo;
      repeat (8) @(posedge i_clk_sys);
      o_sclk <= 1'b0;
    end
    repeat (8) @(posedge i_clk_sys);
    o_csn <= 1'b1;
    o_sda <= ~o_sda;
    repeat (8) @(posedge i_clk_sys);
  endtask : xfer
endmodule : epsc_host

// File: dv/epsc_cmd_decoder_chk.sv
// concurrent checks on the command decoder ports
module epsc_cmd_decoder_chk (
  input wire logic       i_clk_sys,
  input wire logic       i_rstn,
  input wire logic       i_spi_csn,
  input wire logic       o_spi_sda_oe,
  input wire logic       o_busy,
  input wire logic       o_sensor_link_clock_oe,
  input wire logic       o_sensor_link_data_oe,
  input wire epsc_pkg::epsc_boost_t o_boost,
  input wire logic [1:0] o_sleep_mode,
  input wire logic [2:0] o_supply_level,
  input wire logic       o_hv_not_ready,
  input wire logic       o_supply_low,
  input wire logic       o_update_start
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  a_sleep_busy: assert property (o_sleep_mode != 2'h0 |=> o_busy)
    else $error("busy low in deep sleep");
  a_sleep_code: assert property (o_sleep_mode != 2'h2)
    else $error("invalid sleep code stored");
  a_offtime_min: assert property (o_boost.ph1[3:0] >= 4'h4
    && o_boost.ph2[3:0] >= 4'h4 && o_boost.ph3[3:0] >= 4'h4)
    else $error("invalid off time stored");
  a_supply_code: assert property (o_supply_level >= 3'h3)
    else $error("invalid threshold stored");
  a_sda_release: assert property (i_spi_csn [*8] |-> !o_spi_sda_oe)
    else $error("data pin driven while deselected");
  a_sensor_busy: assert property ((o_sensor_link_clock_oe
    || o_sensor_link_data_oe) |-> o_busy)
    else $error("sensor link active while idle");
  a_flag_busy: assert property (($changed(o_hv_not_ready)
    || $changed(o_supply_low)) |-> o_busy || $past(o_busy))
    else $error("detection flag moved while idle");
  a_update_busy: assert property (o_update_start |-> ##[1:2] o_busy)
    else $error("no busy after update start");
  c_update: cover property (o_update_start);
  c_sensor: cover property (o_sensor_link_clock_oe);
  c_hv_fail: cover property ($fell(o_busy) && o_hv_not_ready);
endmodule : epsc_cmd_decoder_chk
bind epsc_cmd_decoder epsc_cmd_decoder_chk u_chk (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_spi_csn(i_spi_csn),
  .o_spi_sda_oe(o_spi_sda_oe), .o_busy(o_busy), .o_boost(o_boost),
  .o_sensor_link_clock_oe(o_sensor_link_clock_oe),
  .o_sensor_link_data_oe(o_sensor_link_data_oe),
  .o_sleep_mode(o_sleep_mode), .o_supply_level(o_supply_level),
  .o_hv_not_ready(o_hv_not_ready), .o_supply_low(o_supply_low),
  .o_update_start(o_update_start));

// File: dv/epsc_cmd_decoder_tb_top.sv
// self-checking bench of the e-paper command decoder
module epsc_cmd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, w9, hv, slo, upd, csn, sck, mo, dc, en;
  logic so, so_oe, busy, sda_oe, hvn, sl, nack;
  logic [31:0] init;
  epsc_pkg::epsc_boost_t bst;
  logic [1:0] slp;
  logic [2:0] lvl;
  logic [7:0] tsrc;
  logic [11:0] temp;
  logic [15:0] ram;
  int error_cnt, checks, k;
  // sensor absent: its data line floats high on the pull-up
  epsc_cmd_decoder #(.COOL_CYC(50)) dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_ce(1'b1), .i_spi_csn(csn),
    .i_iface_width_select(w9), .i_spi_sclk(sck), .i_spi_dc(dc),
    .i_spi_sda(so_oe ? so : mo), .i_clock_gate_enable_bit(en),
    .i_analog_block_enable_bit(en), .i_hv_ready(hv), .i_supply_low(slo),
    .i_update_done(upd), .i_sensor_link_data(~sda_oe), .o_spi_sda(so),
    .o_spi_sda_oe(so_oe), .o_busy(busy), .o_sensor_link_clock(),
    .o_sensor_link_clock_oe(), .o_sensor_link_data(),
    .o_sensor_link_data_oe(sda_oe), .o_init_code(init), .o_boost(bst),
    .o_sleep_mode(slp), .o_supply_level(lvl), .o_temp_source(tsrc),
    .o_temp(temp), .o_ram_opt(ram), .o_hv_not_ready(hvn),
    .o_supply_low(sl), .o_sensor_nack(nack), .o_update_start());
  epsc_host h (.i_clk_sys(clk), .i_w9(w9), .i_sdo(so_oe ? so : mo),
    .o_csn(csn), .o_sclk(sck), .o_sda(mo), .o_dc(dc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, input logic [31:0] p, int n);
    h.xfer(1'b0, op);
    for (int i = n; i > 0; i--) h.xfer(1'b1, p[8*i-1 -: 8]);
  endtask : cmd
  task automatic wait_idle;
    for (int i = 0; busy !== 1'b0 && i < 20000; i++) @(posedge clk);
    chk(busy, 32'h0);
  endtask : wait_idle
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, w9, hv, slo, upd, en} = 6'h1;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(bst, 32'h8b9c960f);
    chk({tsrc, temp, 1'b0, lvl, 2'h0, slp}, 32'h487ff40);
    chk(ram, 32'h0);
    cmd(8'h18, 32'h80, 1);
    cmd(8'h1a, 32'h1230, 2);
    cmd(8'h21, 32'h8408, 2);
    chk({tsrc, temp}, 32'h80123);
    chk(ram, 32'h8408);
    cmd(8'h1b, 32'h0, 1);
    chk(h.rd[7:0], 32'h12);
    h.xfer(1'b1, 8'h00);
    chk(h.rd[7:0], 32'h30);
    cmd(8'h09, 32'hc3a55a3c, 4);
    chk(init, 32'hc3a55a3c);
    cmd(8'h0a, 32'h0, 1);
    chk(h.rd[7:0], 32'hc3);
    cmd(8'h0c, 32'h839fff39, 4);
    chk(bst, 32'h8b9fff39);
    cmd(8'h18, 32'h0, 0);
    cmd(8'h1a, 32'h5670, 2);
    chk({tsrc, temp}, 32'h80567);
    slo <= 1'b1;
    cmd(8'h15, 32'h2, 1);
    chk({busy, lvl}, 32'h4);
    en <= 1'b0;
    cmd(8'h15, 32'h7, 1);
    chk(busy, 32'h0);
    en <= 1'b1;
    cmd(8'h15, 32'h7, 1);
    chk(busy, 32'h1);
    wait_idle();
    chk({lvl, sl}, 32'hf);
    cmd(8'h14, 32'h0, 1);
    chk(busy, 32'h1);
    wait_idle();
    chk(hvn, 32'h1);
    hv <= 1'b1;
    cmd(8'h14, 32'h12, 1);
    for (k = 0; busy === 1'b1 && k < 999; k++) @(posedge clk);
    chk({hvn, k inside {[170:190]}}, 32'h1);
    cmd(8'h1c, 32'hc50000, 3);
    chk(busy, 32'h1);
    wait_idle();
    chk(nack, 32'h1);
    cmd(8'h12, 32'h0, 0);
    chk(busy, 32'h1);
    wait_idle();
    chk({tsrc, temp, 1'b0, lvl, ram}, 40'h487ff40000);
    cmd(8'h20, 32'h0, 0);
    repeat (50) @(posedge clk);
    chk(busy, 32'h1);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    repeat (4) @(posedge clk);
    chk(busy, 32'h0);
    cmd(8'h10, 32'h2, 1);
    chk(slp, 32'h0);
    w9 <= 1'b1;
    @(posedge clk);
    cmd(8'h18, 32'h80, 1);
    chk(tsrc, 32'h80);
    cmd(8'h10, 32'h3, 1);
    cmd(8'h18, 32'h48, 1);
    chk({slp, busy, tsrc}, 32'h780);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk({slp, busy}, 32'h0);
    tally_and_finish();
  end
endmodule : epsc_cmd_decoder_tb_top
